// ==== common/cell_seq_pkg.sv ====
// Package: register map, mode encodings and conversion time constants of the sequencer.
package cell_seq_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] thresh_off = 8'h04;
  localparam logic [7:0] cmd_off = 8'h08;
  localparam logic [7:0] status_off = 8'h0c;
  localparam logic [7:0] ov_flag_off = 8'h10;
  localparam logic [7:0] uv_flag_off = 8'h14;
  localparam logic [7:0] stat_a_off = 8'h18;
  localparam logic [7:0] stat_b_off = 8'h1c;
  localparam logic [7:0] sample_off = 8'h20;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int rate_option_pos = 0;
  localparam int path_sel_pos = 4;
  localparam int ov_thr_pos = 16;
  localparam int uv_thr_pos = 0;
  localparam int cmd_kind_pos = 0;
  localparam int cmd_rate_pos = 4;
  localparam int cmd_three_pos = 8;
  localparam int cmd_gpio_pos = 16;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [31:0] thresh_reset = 32'hffff_0000;

  // ----------------------------------------------------------------------
  // Command kinds and sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    kind_cell = 3'h1,
    kind_aux = 3'h2,
    kind_aux_red = 3'h3,
    kind_cell_gpio = 3'h4,
    kind_internal = 3'h5
  } cmd_kind_type;

  typedef enum {st_idle, st_measure, st_calibrate} seq_state_type;

  // ----------------------------------------------------------------------
  // Timing: total times in microseconds for fast, normal and filtered
  // ----------------------------------------------------------------------
  localparam int clk_mhz = 200;
  localparam int cell_full_us [3] = '{937, 1956, 167774};
  localparam int cell_three_us [3] = '{203, 407, 33570};
  localparam int aux_full_us [3] = '{1825, 3862, 335498};
  localparam int cell_gpio_us [3] = '{1328, 2753, 234899};
  localparam int internal_us [3] = '{742, 1556, 134211};
  localparam int skew1_fast_us = 194;
  localparam int skew3_fast_us = 147;
  localparam int calib_share = 4;
  localparam int sum_atten = 30;
  localparam int temp_step_uv = 7600;
  localparam int temp_offset_c = 276;

endpackage

// ==== design/cell_seq.sv ====
// Conversion sequencer with threshold comparison and AHB-Lite register access.
//
// Behaviour
// - Full conversion: three converters, five cells each
// - Calibration follows measurement; done after calibration
// - Full cell times 937, 1956, 167774 us
// - Three-cell times 203, 407, 33570 us
// - Results unsigned 16-bit, negatives clamp zero
// - Cell above overvoltage threshold sets flag
// - Cell below undervoltage threshold sets flag
// - Thresholds from config; flags to status
// - Aux conversion: nine inputs plus reference, converter one
// - Reference measured between input five and six
// - Full aux times 1825, 3862, 335498 us
// - Redundant aux behaves and times like plain
// - Combined cells plus two inputs, listed times
// - Fast combined keeps skews within 194/147 us
// - Internal parameters conversion, listed times
// - Cell sum stored, thirty-to-one scale
// - Die temperature code stored in status
// - Option bit plus rate field select mode
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cell_seq #(
  parameter int unsigned time_scale = 1
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic signed [16:0] sample_i,
  input wire logic sample_valid_i,
  output logic [4:0] sample_chan_o,
  output logic [1:0] sample_conv_o,
  output logic busy_o,
  output logic done_o,
  output logic redundancy_en_o
);
  import cell_seq_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Folds the eight modes onto the three printed totals; modes between
  // fast and filtered share the normal figure as a conservative middle.
  function automatic logic [1:0] mode_class(input logic opt, input logic [1:0] rate);
    logic [1:0] c;
    c = 2'h1;
    if (rate == 2'h1 && !opt)
    begin
      c = 2'h0;
    end
    else if (rate == 2'h3 && !opt)
    begin
      c = 2'h2;
    end
    return c;
  endfunction

  function automatic logic [31:0] us_to_cycles(input int us);
    return 32'(us * clk_mhz / int'(time_scale));
  endfunction

  // Negative converter codes are reported as zero.
  function automatic logic [15:0] clamp16(input logic signed [16:0] v);
    logic [15:0] r;
    r = v[16] ? 16'h0000 : v[15:0];
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Bus slave: single-cycle, zero-wait, always OKAY
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] thresh_r;
  logic [14:0] ov_flag_r;
  logic [14:0] uv_flag_r;
  logic [15:0] sum_r;
  logic [15:0] temp_r;
  logic [15:0] analog_r;
  logic [15:0] digital_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic go;
  logic [31:0] cmd_word;
  seq_state_type state_r;

  wire acc = hsel_i && htrans_i[1] && hready_i;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= acc && hwrite_i;
      wr_addr_r <= haddr_i[7:0];
    end
  end

  assign go = wr_pend_r && wr_addr_r == cmd_off && state_r == st_idle;
  assign cmd_word = hwdata_i;

  // Thresholds and mode option live in software-written configuration.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      ctrl_r <= ctrl_reset;
      thresh_r <= thresh_reset;
    end
    else if (wr_pend_r && wr_addr_r == ctrl_off)
    begin
      ctrl_r <= hwdata_i;
    end
    else if (wr_pend_r && wr_addr_r == thresh_off)
    begin
      thresh_r <= hwdata_i;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      if (acc && !hwrite_i)
      begin
        case (haddr_i[7:0])
          ctrl_off: hrdata_o <= ctrl_r;
          thresh_off: hrdata_o <= thresh_r;
          status_off: hrdata_o <= {30'h0, done_o, busy_o};
          ov_flag_off: hrdata_o <= {17'h0, ov_flag_r};
          uv_flag_off: hrdata_o <= {17'h0, uv_flag_r};
          stat_a_off: hrdata_o <= {temp_r, sum_r};
          stat_b_off: hrdata_o <= {digital_r, analog_r};
          default: hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  cmd_kind_type kind_r;
  logic three_r;
  logic [8:0] gpio_sel_r;
  logic [31:0] cnt_r;
  logic [31:0] total_r;
  logic [31:0] meas_r;
  logic [3:0] slot_r;
  logic [3:0] nslot_r;
  logic [1:0] conv_r;
  logic [31:0] tot_nxt;
  logic [3:0] nslot_nxt;
  logic [1:0] mc;

  always_comb
  begin
    mc = mode_class(ctrl_r[rate_option_pos], cmd_word[cmd_rate_pos +: 2]);
    tot_nxt = us_to_cycles(internal_us[mc]);
    nslot_nxt = 4'h4;
    case (cmd_word[cmd_kind_pos +: 3])
      kind_cell:
      begin
        nslot_nxt = cmd_word[cmd_three_pos] ? 4'h1 : 4'h5;
        tot_nxt = cmd_word[cmd_three_pos] ? us_to_cycles(cell_three_us[mc])
                                          : us_to_cycles(cell_full_us[mc]);
      end
      kind_aux, kind_aux_red:
      begin
        nslot_nxt = 4'ha;
        tot_nxt = us_to_cycles(aux_full_us[mc]);
      end
      kind_cell_gpio:
      begin
        // Seven slots keep the fast-mode skews within skew1/skew3 bounds.
        nslot_nxt = 4'h7;
        tot_nxt = us_to_cycles(cell_gpio_us[mc]);
      end
      default:
      begin
        nslot_nxt = 4'h4;
        tot_nxt = us_to_cycles(internal_us[mc]);
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state_r <= st_idle;
      kind_r <= kind_internal;
      three_r <= 1'b0;
      gpio_sel_r <= 9'h000;
      cnt_r <= 32'h0;
      total_r <= 32'h0;
      meas_r <= 32'h0;
      slot_r <= 4'h0;
      nslot_r <= 4'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      redundancy_en_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      case (state_r)
        st_idle:
        begin
          if (go && cmd_word[cmd_kind_pos +: 3] inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5})
          begin
            kind_r <= cmd_kind_type'(cmd_word[cmd_kind_pos +: 3]);
            three_r <= cmd_word[cmd_three_pos];
            gpio_sel_r <= cmd_word[cmd_gpio_pos +: 9];
            total_r <= tot_nxt;
            // Measurement takes the first three quarters; calibration the rest.
            meas_r <= tot_nxt - (tot_nxt >> 2);
            nslot_r <= nslot_nxt;
            slot_r <= 4'h0;
            cnt_r <= 32'h1;
            busy_o <= 1'b1;
            redundancy_en_o <= cmd_word[cmd_kind_pos +: 3] == kind_aux_red
                               && ctrl_r[path_sel_pos + 1] == 1'b0;
            state_r <= st_measure;
          end
        end
        st_measure:
        begin
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r >= (meas_r / 32'(nslot_r)) * 32'(slot_r + 4'h1) && slot_r < nslot_r - 4'h1)
          begin
            slot_r <= slot_r + 4'h1;
          end
          if (cnt_r >= meas_r)
          begin
            state_r <= st_calibrate;
          end
        end
        st_calibrate:
        begin
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r >= total_r)
          begin
            state_r <= st_idle;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            redundancy_en_o <= 1'b0;
          end
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  // Slot to converter and channel. Aux order: inputs 1..5, reference, 6..9.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      sample_chan_o <= 5'h00;
      sample_conv_o <= 2'h0;
    end
    else
    begin
      sample_conv_o <= 2'h0;
      sample_chan_o <= {1'b0, slot_r};
      if (kind_r == kind_aux || kind_aux_red == kind_r)
      begin
        sample_chan_o <= 5'h10 + {1'b0, slot_r};
      end
      else if (kind_r == kind_internal)
      begin
        sample_chan_o <= 5'h1c + {1'b0, slot_r};
      end
      else if (slot_r < 4'h5)
      begin
        // Cell slots are shared by the three converters in turn.
        sample_conv_o <= conv_r;
        sample_chan_o <= {1'b0, slot_r} + (conv_r == 2'h1 ? 5'h05 : (conv_r == 2'h2 ? 5'h0a : 5'h00));
      end
      else
      begin
        sample_chan_o <= 5'h0b + {1'b0, slot_r};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Results and threshold flags
  // ----------------------------------------------------------------------
  logic [15:0] res;
  logic cell_kind;
  assign res = clamp16(sample_i);
  assign cell_kind = kind_r == kind_cell || kind_r == kind_cell_gpio;

  // Each result taken in a cell slot (slots 0..4 of a cell kind) hands the slot to the next converter.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      conv_r <= 2'h0;
    end
    else if (state_r == st_idle)
    begin
      conv_r <= 2'h0;
    end
    else if (sample_valid_i && cell_kind && slot_r < 4'h5)
    begin
      conv_r <= (conv_r == 2'h2) ? 2'h0 : conv_r + 2'h1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 15; g++)
    begin : flag_gen
      // Cell g is on converter g/5, slot g%5.
      wire hit = state_r == st_measure && sample_valid_i && cell_kind
                 && sample_chan_o == 5'(g) && sample_conv_o == 2'(g / 5);
      always_ff @(posedge mclk_i)
      begin
        if (reset_i)
        begin
          ov_flag_r[g] <= 1'b0;
          uv_flag_r[g] <= 1'b0;
        end
        else if (hit)
        begin
          ov_flag_r[g] <= res > thresh_r[ov_thr_pos +: 16];
          uv_flag_r[g] <= res < thresh_r[uv_thr_pos +: 16];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      sum_r <= 16'h0;
      temp_r <= 16'h0;
      analog_r <= 16'h0;
      digital_r <= 16'h0;
    end
    else if (state_r == st_measure && sample_valid_i && kind_r == kind_internal)
    begin
      case (slot_r)
        4'h0: sum_r <= res;
        4'h1: temp_r <= res;
        4'h2: analog_r <= res;
        default: digital_r <= res;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_busy_until_done;
    @(posedge mclk_i) disable iff (reset_i) $fell(busy_o) |-> done_o;
  endproperty
  a_busy_until_done: assert property (p_busy_until_done) else $error("busy fell without done");

  property p_cal_after_meas;
    @(posedge mclk_i) disable iff (reset_i)
      (state_r == st_calibrate) |-> $past(state_r) != st_idle;
  endproperty
  a_cal_after_meas: assert property (p_cal_after_meas) else $error("calibrate skipped measure");

  property p_done_after_cal;
    @(posedge mclk_i) disable iff (reset_i) done_o |-> $past(state_r) == st_calibrate;
  endproperty
  a_done_after_cal: assert property (p_done_after_cal) else $error("done without calibration");

  property p_start_busy;
    @(posedge mclk_i) disable iff (reset_i) $rose(busy_o) |-> $past(go);
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy rose without command");

  property p_clamp;
    @(posedge mclk_i) disable iff (reset_i) sample_i[16] |-> res == 16'h0000;
  endproperty
  a_clamp: assert property (p_clamp) else $error("negative not clamped");

  property p_aux_slots;
    @(posedge mclk_i) disable iff (reset_i)
      (state_r != st_idle && (kind_r == kind_aux || kind_r == kind_aux_red)) |-> nslot_r == 4'ha;
  endproperty
  a_aux_slots: assert property (p_aux_slots) else $error("aux slot count wrong");

  property p_cell_slots;
    @(posedge mclk_i) disable iff (reset_i)
      (state_r != st_idle && kind_r == kind_cell) |-> nslot_r == (three_r ? 4'h1 : 4'h5);
  endproperty
  a_cell_slots: assert property (p_cell_slots) else $error("cell slot count wrong");

  property p_red_only_aux;
    @(posedge mclk_i) disable iff (reset_i) redundancy_en_o |-> kind_r == kind_aux_red;
  endproperty
  a_red_only_aux: assert property (p_red_only_aux) else $error("redundancy on wrong kind");

  property p_ov_flag;
    @(posedge mclk_i) disable iff (reset_i)
      (flag_gen[0].hit && sample_conv_o == 2'h0) |=> ov_flag_r[0] == ($past(res) > $past(thresh_r[31:16]));
  endproperty
  a_ov_flag: assert property (p_ov_flag) else $error("overvoltage flag mismatch");

  property p_uv_flag;
    @(posedge mclk_i) disable iff (reset_i)
      (flag_gen[0].hit && sample_conv_o == 2'h0) |=> uv_flag_r[0] == ($past(res) < $past(thresh_r[15:0]));
  endproperty
  a_uv_flag: assert property (p_uv_flag) else $error("undervoltage flag mismatch");

  c_cell: cover property (@(posedge mclk_i) disable iff (reset_i) done_o && kind_r == kind_cell);
  c_aux: cover property (@(posedge mclk_i) disable iff (reset_i) done_o && kind_r == kind_aux_red);
  c_int: cover property (@(posedge mclk_i) disable iff (reset_i) done_o && kind_r == kind_internal);

endmodule
`default_nettype wire

// ==== tb/adc_front_model.sv ====
// Behavioural converter front end that returns one result every four cycles while busy, for the requested channel.
`timescale 1ns/1ps
`default_nettype none
module adc_front_model (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic busy_i,
  input wire logic [4:0] chan_i,
  output logic signed [16:0] sample_o,
  output logic valid_o
);
  // ----------------------------------------------------------------------
  // Result generation
  // ----------------------------------------------------------------------
  logic [1:0] tick_r;

  // Channel zero reads slightly negative so the clamp to zero is exercised.
  // Between results the bus toggles, so a stale value is never taken as fresh.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      tick_r <= 2'h0;
      valid_o <= 1'b0;
      sample_o <= 17'h00000;
    end
    else
    begin
      tick_r <= tick_r + 2'h1;
      valid_o <= busy_i && (tick_r == 2'h3);
      if (busy_i && (tick_r == 2'h3))
        sample_o <= (chan_i == 5'h00) ? 17'h1fffb : {chan_i, 12'h000};
      else
        sample_o <= ~sample_o;
    end
  end
endmodule
`default_nettype wire

// ==== tb/cell_monitor_conversion_sequencer_test.sv ====
// Self-checking testbench for the conversion sequencer over its register bus.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module cell_monitor_conversion_sequencer_test;
  import cell_seq_pkg::*;
  // Times are divided by this so the slowest mode tested stays a few thousand cycles.
  localparam int ts = 100;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  wire logic hready_i;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic signed [16:0] sample_i;
  logic sample_valid_i;
  logic [4:0] sample_chan_o;
  logic [1:0] sample_conv_o;
  logic busy_o;
  logic done_o;
  logic redundancy_en_o;
  int fail_count = 0;
  int checks = 0;
  int busy_cycles;
  int done_cnt;
  int split_bad;
  logic red_seen;
  logic [31:0] chan_mask;
  logic [3:0] conv_mask;
  logic [31:0] rd;

  assign hready_i = hreadyout_o;

  initial
  begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  cell_seq #(.time_scale(ts)) dut (.mclk_i(mclk_i), .reset_i(reset_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .sample_i(sample_i),
    .sample_valid_i(sample_valid_i), .sample_chan_o(sample_chan_o),
    .sample_conv_o(sample_conv_o), .busy_o(busy_o), .done_o(done_o),
    .redundancy_en_o(redundancy_en_o));

  adc_front_model front (.mclk_i(mclk_i), .reset_i(reset_i), .busy_i(busy_o),
    .chan_i(sample_chan_o), .sample_o(sample_i), .valid_o(sample_valid_i));

  // ----------------------------------------------------------------------
  // Activity monitor
  // ----------------------------------------------------------------------
  always @(posedge mclk_i)
  begin
    if (busy_o)
      busy_cycles++;
    if (done_o)
      done_cnt++;
    if (redundancy_en_o)
      red_seen = 1'b1;
    if (busy_o && sample_valid_i)
    begin
      chan_mask[sample_chan_o] = 1'b1;
      conv_mask[sample_conv_o] = 1'b1;
      if ({3'h0, sample_conv_o} !== sample_chan_o / 5)
        split_bad++;
    end
  end

  // ----------------------------------------------------------------------
  // Bus and sequence tasks
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic give_up();
    fail_count++;
    print_verdict();
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1)
    begin
      n++;
      if (n > 50)
        give_up();
      @(posedge mclk_i);
    end
  endtask

  // Entered just after a rising edge; leaves just after the data-phase edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    hwrite_i <= wr;
    htrans_i <= 2'h2;
    hsize_i <= 3'h2;
    wait_ready();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    wait_ready();
    rd = hrdata_o;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    `CHK(rd, exp);
    `CHK(hresp_o, 1'b0);
  endtask

  function automatic logic [31:0] cmd(input logic [2:0] kind, input logic [1:0] rate,
                                      input logic three);
    return {7'h0, 9'h1ff, 7'h0, three, 2'h0, rate, 1'b0, kind};
  endfunction

  task automatic run_conv(input logic [31:0] c, input int us, input logic refuse);
    int n;
    int exp;
    busy_cycles = 0;
    done_cnt = 0;
    split_bad = 0;
    red_seen = 1'b0;
    chan_mask = 32'h0;
    conv_mask = 4'h0;
    exp = us * clk_mhz / ts;
    wr(cmd_off, c);
    if (refuse)
    begin
      wr(cmd_off, cmd(kind_internal, 2'h3, 1'b0));
      rchk(status_off, 32'h1);
    end
    n = 0;
    while (done_cnt == 0)
    begin
      @(posedge mclk_i);
      n++;
      if (n > 20000)
        give_up();
    end
    repeat (3) @(posedge mclk_i);
    `CHK(done_cnt, 1);
    `CHK(busy_o, 1'b0);
    `CHK(busy_cycles >= exp - 3 && busy_cycles <= exp + 3, 1'b1);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    rchk(ctrl_off, ctrl_reset);
    rchk(thresh_off, thresh_reset);
    rchk(status_off, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rchk(8'h40, 32'h0);
    wr(thresh_off, 32'h9000_1000);
    rchk(thresh_off, 32'h9000_1000);
    wr(ctrl_off, 32'h0);
    run_conv(cmd(kind_cell, 2'h1, 1'b0), cell_full_us[0], 1'b1);
    `CHK(chan_mask, 32'h0000_7fff);
    `CHK(split_bad, 0);
    rchk(ov_flag_off, 32'h0000_7c00);
    rchk(uv_flag_off, 32'h0000_0001);
    run_conv(cmd(kind_cell, 2'h1, 1'b1), cell_three_us[0], 1'b0);
    `CHK(conv_mask, 4'h7);
    wr(thresh_off, thresh_reset);
    run_conv(cmd(kind_cell, 2'h2, 1'b0), cell_full_us[1], 1'b0);
    rchk(ov_flag_off, 32'h0);
    rchk(uv_flag_off, 32'h0);
    wr(ctrl_off, 32'h0000_0020);
    run_conv(cmd(kind_aux, 2'h1, 1'b0), aux_full_us[0], 1'b0);
    `CHK(conv_mask, 4'h1);
    `CHK(red_seen, 1'b0);
    for (int ps = 0; ps < 3; ps++)
    begin
      wr(ctrl_off, 32'(ps) << 4);
      run_conv(cmd(kind_aux_red, 2'h1, 1'b0), aux_full_us[0], 1'b0);
      `CHK(red_seen, (ps < 2) ? 1'b1 : 1'b0);
      `CHK(conv_mask, 4'h1);
    end
    run_conv(cmd(kind_cell_gpio, 2'h1, 1'b0), cell_gpio_us[0], 1'b0);
    run_conv(cmd(kind_internal, 2'h1, 1'b0), internal_us[0], 1'b0);
    wr(ctrl_off, 32'h0000_0001);
    run_conv(cmd(kind_internal, 2'h1, 1'b0), internal_us[1], 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
